// ---- sim/formatter_props.sv ----
// Purpose: Port checks for the legacy formatter
// Assumes: One clock domain, reset active low
// Notes:   Bound onto the top module by port name
`timescale 1ns/1ns
`default_nettype none
module formatter_props (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  // Record stream and status
  input wire logic [7:0]  outByte,
  input wire logic        outValid,
  input wire logic        outLast,
  input wire logic        outReady,
  input wire logic        errFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Write address, ff when idle since ff is unmapped
  logic [7:0] wa;
  assign wa = regWrite ? regAddr : 8'hff;
  // Bytes taken so far in this record
  logic [6:0] cnt_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cnt_reg <= 7'h0;
    else if (outValid && outReady) cnt_reg <= outLast ? 7'h0 : cnt_reg + 7'h1;
  end
  sequence s_take; outValid && outReady; endsequence
  sequence s_end; s_take ##0 outLast; endsequence
  a_read_slot: assert property (!$past(regRead) |-> regRdData == 32'h0)
    else $error("read data outside its slot");
  a_hold_byte: assert property (outValid && !outReady |=> outValid && $stable(outByte))
    else $error("byte not held");
  a_first_tag: assert property ($rose(outValid) |-> outByte == 8'h44)
    else $error("record start byte");
  a_field_comma: assert property (s_take ##0 cnt_reg == 7'd24 |-> outByte == 8'h2c)
    else $error("field separator");
  a_rec_len: assert property (s_end |-> cnt_reg == 7'd73 ##1 !outValid)
    else $error("record length");
  a_last_digit: assert property (outLast |-> outByte inside {[8'h30:8'h39]})
    else $error("last byte not a digit");
  a_bad_chan: assert property (wa == 8'h00 && regWrData[3:0] == 4'hf |=> errFlag)
    else $error("channel 15 taken");
  a_bad_volt: assert property (wa == 8'h0c && regWrData[4:0] > 5'd10 |=> errFlag)
    else $error("voltage code taken");
  a_err_hold: assert property (errFlag && wa != 8'h20 |=> errFlag)
    else $error("error flag lost");
endmodule
bind legacy_command_output_formatter formatter_props u_props (.*);
`default_nettype wire

// ---- sim/legacy_command_output_formatter_tb_top.sv ----
// Purpose: Self-checking bench for the legacy formatter
// Assumes: 25 MHz clock, reset held 20 cycles
// Notes:   Record bytes expected from the measured values set below
`timescale 1ns/1ns
`default_nettype none
module legacy_command_output_formatter_tb_top;
  logic        sys_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0]  regAddr = 8'h0;
  logic [31:0] regWrData = 32'h0;
  logic        integOption = 1'b0, motorOption = 1'b0, sensorOption = 1'b0;
  logic        fourWireModel = 1'b0, romRev201 = 1'b0, slow = 1'b0;
  // Ch1 minus E-3 normal, ch2 overrange, ch3 current frequency E+6 overflow
  logic [2:0]  measSign = 3'h1, measFreqCur = 3'h4;
  logic [83:0] measDigits = 84'h1234567;
  logic [8:0]  measPoint = 9'h0ff;
  logic [5:0]  measExp = 6'h30, measState = 6'h24;
  logic [31:0] regRdData;
  logic [7:0]  outByte;
  logic        outValid, outLast, outReady, errFlag;
  int          error_cnt = 0, tests_run = 0;
  // 40 ns clock
  always #20 sys_clk = ~sys_clk;
  legacy_command_output_formatter u_dut (.*);
  record_sink u_sink (.sys_clk, .slow, .outByte, .outValid, .outReady);
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  // Read data stand one cycle only, so take them mid-cycle
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    check(regRdData & m, e);
  endtask
  // Write, check status for code c (0 none), then clear it
  task wec(input logic [7:0] a, input logic [31:0] d, input logic [7:0] c);
    wr(a, d);
    rd(8'h20, c != 8'h0 ? 32'hff01 : 32'h1, {c, 7'h0, c != 8'h0});
    wr(8'h20, 32'h1);
  endtask
  task cs(input int b, input string s);
    for (int i = 0; i < s.len(); i++) check(u_sink.rec[b + i], s[i]);
  endtask
  task t_ranges;
    rd(8'h08, 32'h1f, 32'h9);
    rd(8'h0c, 32'h1f, 32'ha);
    wec(8'h08, 32'h12, 8'd12);
    sensorOption <= 1'b1;
    wec(8'h08, 32'h17, 8'h0);
    wec(8'h08, 32'ha, 8'd12);
    rd(8'h08, 32'h1f, 32'h17);
    wec(8'h0c, 32'hb, 8'd12);
    wec(8'h0c, 32'h3, 8'h0);
    $display("ranges end");
  endtask
  task t_assign;
    integOption <= 1'b1;
    motorOption <= 1'b1;
    fourWireModel <= 1'b1;
    // Item codes 0 to 39 on channel 3, element 1
    for (int i = 0; i < 40; i++) begin
      wec(8'h00, 32'h10003 | (i << 8), i inside {8, 28, [16:23], [36:39]} ? 8'd12 : 8'h0);
    end
    wr(8'h04, 32'h3);
    rd(8'h00, 32'h73f00, 32'h12300);
    wec(8'h00, 32'h40c01, 8'd12);
    wec(8'h00, 32'h40001, 8'h0);
    wec(8'h00, 32'h1000f, 8'd12);
    wec(8'h00, 32'h1010e, 8'h0);
    integOption <= 1'b0;
    motorOption <= 1'b0;
    fourWireModel <= 1'b0;
    wec(8'h00, 32'h10901, 8'd12);
    wec(8'h00, 32'h11e01, 8'd12);
    wec(8'h00, 32'h20101, 8'd12);
    integOption <= 1'b1;
    $display("assign end");
  endtask
  task t_setup;
    wec(8'h14, 32'h1, 8'd12);
    wec(8'h14, 32'h5, 8'd12);
    wec(8'h14, 32'h3, 8'h0);
    wec(8'h10, 32'd1000, 8'd12);
    romRev201 <= 1'b1;
    wec(8'h10, 32'd1000, 8'h0);
    wec(8'h10, 32'd100000001, 8'd12);
    wr(8'h18, 32'h2);
    wec(8'h24, 32'h1, 8'd11);
    wec(8'h24, 32'h2, 8'd11);
    wr(8'h1c, 32'h21);
    wr(8'h24, 32'h4);
    rd(8'h2c, 32'h11f, 32'h117);
    rd(8'h28, 32'h11f, 32'h3);
    rd(8'h30, 32'h3, 32'h2);
    rd(8'h34, 32'h7ffffff, 32'd1000);
    rd(8'h38, 32'h3, 32'h2);
    $display("setup end");
  endtask
  task t_record;
    wr(8'h00, 32'h10101);
    wr(8'h00, 32'h10f02);
    wr(8'h00, 32'h30703);
    wr(8'h18, 32'h102);
    slow <= 1'b1;
    wr(8'h24, 32'h1);
    wec(8'h24, 32'h1, 8'd11);
    repeat (400) begin
      @(posedge sys_clk);
      if (u_sink.n == 74) break;
    end
    check(u_sink.n, 74);
    cs(0, "DA01EA1N");
    cs(12, "-");
    cs(13, "1234567 ");
    cs(21, "E-3");
    cs(24, ",DB4 EB1I");
    cs(50, "DC08EC3O");
    cs(63, "0000.000");
    cs(71, "E+6");
    $display("record end");
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_ranges;
    t_assign;
    t_setup;
    t_record;
    print_verdict;
  end
  // Watchdog, well past the fewer than a thousand cycles needed
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire

// ---- sim/record_sink.sv ----
// Purpose: Host side sink for record bytes
// Assumes: Runs on sys_clk
// Notes:   Slow mode stalls every other cycle
`timescale 1ns/1ns
`default_nettype none
module record_sink (
  // Clock and pacing
  input wire logic       sys_clk,
  input wire logic       slow,
  // Record stream
  input wire logic [7:0] outByte,
  input wire logic       outValid,
  output logic           outReady
);
  logic [7:0] rec [0:79];
  int         n = 0;
  logic       phase = 1'b0;
  // A busy host only takes a byte on alternate cycles
  always @(posedge sys_clk) begin
    phase <= !phase;
    if (outValid && outReady) begin
      rec[n] <= outByte;
      n <= n + 1;
    end
  end
  assign outReady = !slow || phase;
endmodule
`default_nettype wire

// ---- verilog/formatter_regs.vh ----
// Purpose: Register map, codes and record layout of the legacy formatter
// Assumes: Included by both design files
// Notes:   Definitions only
`ifndef FORMATTER_REGS_VH
`define FORMATTER_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_ASSIGN 8'h00
`define A_QCH    8'h04
`define A_CUR    8'h08
`define A_VOLT   8'h0c
`define A_GAIN   8'h10
`define A_WIRE   8'h14
`define A_GROUP  8'h18
`define A_AUTO   8'h1c
`define A_STAT   8'h20
`define A_ACT    8'h24
`define A_L2     8'h28
`define A_L3     8'h2c
`define A_L7     8'h30
`define A_L8     8'h34
`define A_L15    8'h38
// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_CH     3:0
`define F_ITEM   13:8
`define F_ELEM   18:16
`define F_SPAN   4:0
`define F_GAIN   26:0
`define F_WIRE   2:0
`define F_GRP    1:0
`define F_MODEB  8
`define F_CAUTO  0
`define F_VAUTO  1
`define F_MODE   5:4
`define F_ERR    0
`define F_RPT    16
`define F_BUSY   17
`define ACT_REC  0
`define ACT_NAT  1
`define ACT_ALT  2
// ----------------------------------------
// Codes and limits
// ----------------------------------------
`define CH_MIN     4'd1
`define CH_MAX     4'd14
`define IT_NONE    6'd0
`define IT_V       6'd1
`define IT_A       6'd2
`define IT_W       6'd3
`define IT_VAR     6'd4
`define IT_VA      6'd5
`define IT_PF      6'd6
`define IT_FRQ     6'd7
`define IT_FCUR    6'd8
`define IT_WH      6'd9
`define IT_AH      6'd10
`define IT_DEG     6'd11
`define IT_VPK     6'd12
`define IT_APK     6'd13
`define IT_CALC    6'd14
`define IT_ETIME   6'd15
`define IT_WHP     6'd24
`define IT_WHN     6'd25
`define IT_AHP     6'd26
`define IT_AHN     6'd27
`define IT_MOT_LO  6'd29
`define IT_MOT_HI  6'd35
`define EL_1       3'd1
`define EL_2       3'd2
`define EL_SUM     3'd4
`define CUR_LO     5'd4
`define CUR_HI     5'd9
`define SEN_LO     5'd18
`define SEN_HI     5'd23
`define VOLT_LO    5'd3
`define VOLT_HI    5'd10
`define WIRE_3P4W  3'd1
`define WIRE_3V3A  3'd4
`define GAIN_MIN0  27'd9000
`define GAIN_MIN1  27'd1000
`define GAIN_MAX   27'd100000000
`define K_DEF      32'd10000
`define MODE_MAX   2'd2
`define GRP_LEGACY 2'd2
`define ERR_PARAM  8'd12
`define ERR_CMD    8'd11
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CUR_RST    5'd9
`define VOLT_RST   5'd10
`define GAIN_RST   27'd10000
`define WIRE_RST   3'd0
`define GRP_RST    2'd0
// ----------------------------------------
// Record layout (byte positions)
// ----------------------------------------
`define P_STATE    5'd7
`define P_UNIT     5'd8
`define P_HEND     5'd11
`define P_SIGN     5'd12
`define P_MANT     5'd13
`define P_EXPE     5'd21
`define P_SEP      5'd24
`define LAST_CH    2'd2
`endif

// ---- verilog/legacy_command_output_formatter.v ----
// Purpose: Legacy command interpreter and measurement record formatter
// Assumes: Commands arrive as register writes from a host-side front end
// Notes:   Straps come from logic on sys_clk; measured data must hold
//          stable while a record is being sent
`timescale 1ns/1ns
`default_nettype none
`include "formatter_regs.vh"
// How it works
// - Assignment gives channel 1-14, item, element; one stored per channel.
// - Items 0-7 and 11-14 always decode as basic quantities.
// - Items 9, 10, 15, 24-27 accepted only with the integration option.
// - Items 29-35 accepted only with the motor option.
// - Elements 1-3 and sum 4; element 2 needs four-wire; no sum for peaks.
// - Items 0, 7, 14, 15, 29-35 accept any element code 1-4.
// - Setup report captures lines 2, 3, 7, 8 and 15 for reading.
// - Setup report shows element 1 values.
// - Native setup report is rejected in the legacy group.
// - Current codes 4-9 direct, 18-23 sensor ranges with sensor option.
// - Current range set for all elements; mismatch on query raises 12.
// - Voltage codes 3-10 set for all elements at once.
// - Sensor gain one value; lower bound by revision, upper 100000000.
// - Wiring codes 0-4; codes 1 and 4 need the four-wire model.
// - Records need mode B and send channels 1 to 3 assignments.
// - Each field is 12 header bytes, 12 data bytes, comma separated.
// - Header bytes 1-2 carry DA, DB or DC.
// - Header bytes 3-4 carry type code; frequency splits into 7 or 8.
// - Channel 2 with type 15 sends DB4 in the first four bytes.
// - Bytes 5-6 carry EA, EB or EC; byte 7 the element digit.
// - Byte 8 is N, I or O for the data state.
// - Data is sign, mantissa up to seven digits, then exponent.
module legacy_command_output_formatter (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdData,
  // Model straps
  input  wire        integOption,
  input  wire        motorOption,
  input  wire        sensorOption,
  input  wire        fourWireModel,
  input  wire        romRev201,
  // Measured data, channels 1 to 3
  input  wire [2:0]  measSign,
  input  wire [83:0] measDigits,
  input  wire [8:0]  measPoint,
  input  wire [5:0]  measExp,
  input  wire [5:0]  measState,
  input  wire [2:0]  measFreqCur,
  // Record byte stream
  output reg  [7:0]  outByte,
  output reg         outValid,
  output reg         outLast,
  input  wire        outReady,
  // Status
  output reg         errFlag
);
  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  // Item code allowed for this model
  function itemOk;
    input [5:0] it;
    input       integ;
    input       motor;
    begin
      if (it <= `IT_FRQ || (it >= `IT_DEG && it <= `IT_CALC))
        itemOk = 1'b1;
      else if (it == `IT_WH || it == `IT_AH || it == `IT_ETIME ||
               (it >= `IT_WHP && it <= `IT_AHN))
        itemOk = integ;
      else if (it >= `IT_MOT_LO && it <= `IT_MOT_HI)
        itemOk = motor;
      else
        itemOk = 1'b0;
    end
  endfunction

  // Element code allowed for this item and model
  function elemOk;
    input [5:0] it;
    input [2:0] el;
    input       four;
    begin
      if (el < `EL_1 || el > `EL_SUM)
        elemOk = 1'b0;
      else if (it == `IT_NONE || it == `IT_FRQ || it == `IT_CALC ||
               it == `IT_ETIME || (it >= `IT_MOT_LO && it <= `IT_MOT_HI))
        elemOk = 1'b1;
      else if (el == `EL_2 && !four)
        elemOk = 1'b0;
      else if (el == `EL_SUM && (it == `IT_VPK || it == `IT_APK))
        elemOk = 1'b0;
      else
        elemOk = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  reg [5:0]  assignItem [0:13];
  reg [2:0]  assignElem [0:13];
  reg [4:0]  curSpan    [0:2];
  reg [4:0]  voltSpan   [0:2];
  reg [3:0]  queryCh_reg;
  reg [26:0] gain_reg;
  reg [2:0]  wiring_reg;
  reg [1:0]  group_reg;
  reg        modeB_reg;
  reg        curAuto_reg;
  reg        voltAuto_reg;
  reg [1:0]  measMode_reg;
  reg [7:0]  errCode_reg;
  reg        reportReady_reg;
  reg [31:0] snapL2_reg;
  reg [31:0] snapL3_reg;
  reg [31:0] snapL7_reg;
  reg [31:0] snapL8_reg;
  reg [31:0] snapL15_reg;
  reg        state_reg;
  reg [1:0]  chIdx_reg;
  reg [4:0]  pos_reg;
  integer    i;

  // Write decode results
  reg        errSet;
  reg [7:0]  errSetCode;
  reg        doAssign;
  reg        doCur;
  reg        doVolt;
  reg        doGain;
  reg        doWire;
  reg        doAuto;
  reg        doSnap;
  reg        doRecord;
  reg [31:0] rdNext;

  wire [3:0]  wCh   = regWrData[`F_CH];
  wire [5:0]  wItem = regWrData[`F_ITEM];
  wire [2:0]  wElem = regWrData[`F_ELEM];
  wire [4:0]  wSpan = regWrData[`F_SPAN];
  wire [26:0] wGain = regWrData[`F_GAIN];
  wire [2:0]  wWire = regWrData[`F_WIRE];
  wire [26:0] gainMin = romRev201 ? `GAIN_MIN1 : `GAIN_MIN0;
  wire        legacy = (group_reg == `GRP_LEGACY);
  wire        curSame = (curSpan[0] == curSpan[1]) && (curSpan[1] == curSpan[2]);
  wire        voltSame = (voltSpan[0] == voltSpan[1]) && (voltSpan[1] == voltSpan[2]);
  wire [3:0]  qIdx = queryCh_reg - `CH_MIN;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Each command except the group and status writes checks its parameter before anything is stored
  always @* begin
    errSet = 1'b0;
    errSetCode = `ERR_PARAM;
    doAssign = 1'b0;
    doCur = 1'b0;
    doVolt = 1'b0;
    doGain = 1'b0;
    doWire = 1'b0;
    doAuto = 1'b0;
    doSnap = 1'b0;
    doRecord = 1'b0;
    if (regWrite) begin
      if (regAddr == `A_ASSIGN) begin
        if (wCh >= `CH_MIN && wCh <= `CH_MAX &&
            itemOk(wItem, integOption, motorOption) &&
            elemOk(wItem, wElem, fourWireModel))
          doAssign = 1'b1;
        else
          errSet = 1'b1;
      end else if (regAddr == `A_QCH) begin
        errSet = !(wCh >= `CH_MIN && wCh <= `CH_MAX);
      end else if (regAddr == `A_CUR) begin
        if ((wSpan >= `CUR_LO && wSpan <= `CUR_HI) ||
            (sensorOption && wSpan >= `SEN_LO && wSpan <= `SEN_HI))
          doCur = 1'b1;
        else
          errSet = 1'b1;
      end else if (regAddr == `A_VOLT) begin
        doVolt = (wSpan >= `VOLT_LO && wSpan <= `VOLT_HI);
        errSet = !doVolt;
      end else if (regAddr == `A_GAIN) begin
        doGain = (regWrData[31:27] == 5'd0) && (wGain >= gainMin) &&
                 (wGain <= `GAIN_MAX);
        errSet = !doGain;
      end else if (regAddr == `A_WIRE) begin
        doWire = (wWire <= `WIRE_3V3A) && (fourWireModel ||
                 (wWire != `WIRE_3P4W && wWire != `WIRE_3V3A));
        errSet = !doWire;
      end else if (regAddr == `A_AUTO) begin
        doAuto = (regWrData[`F_MODE] <= `MODE_MAX);
        errSet = !doAuto;
      end else if (regAddr == `A_ACT) begin
        if (regWrData[`ACT_REC]) begin
          // Records only in the legacy group with mode B, one at a time
          doRecord = legacy && modeB_reg && (state_reg == ST_IDLE);
          errSet = !doRecord;
          errSetCode = `ERR_CMD;
        end else if (regWrData[`ACT_NAT]) begin
          doSnap = !legacy;
          errSet = legacy;
          errSetCode = `ERR_CMD;
        end else if (regWrData[`ACT_ALT]) begin
          doSnap = 1'b1;
        end
      end
    end else if (regRead) begin
      // Range queries fail when elements disagree
      if (regAddr == `A_CUR && !curSame) errSet = 1'b1;
      if (regAddr == `A_VOLT && !voltSame) errSet = 1'b1;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rdNext = 32'h0000_0000;
    if (regAddr == `A_ASSIGN) begin
      rdNext[`F_CH] = queryCh_reg;
      rdNext[`F_ITEM] = assignItem[qIdx];
      rdNext[`F_ELEM] = assignElem[qIdx];
    end else if (regAddr == `A_QCH) rdNext[`F_CH] = queryCh_reg;
    else if (regAddr == `A_CUR) rdNext[`F_SPAN] = curSpan[0];
    else if (regAddr == `A_VOLT) rdNext[`F_SPAN] = voltSpan[0];
    else if (regAddr == `A_GAIN) rdNext[`F_GAIN] = gain_reg;
    else if (regAddr == `A_WIRE) rdNext[`F_WIRE] = wiring_reg;
    else if (regAddr == `A_GROUP) begin
      rdNext[`F_GRP] = group_reg;
      rdNext[`F_MODEB] = modeB_reg;
    end else if (regAddr == `A_AUTO) begin
      rdNext[`F_CAUTO] = curAuto_reg;
      rdNext[`F_VAUTO] = voltAuto_reg;
      rdNext[`F_MODE] = measMode_reg;
    end else if (regAddr == `A_STAT) begin
      rdNext[`F_ERR] = errFlag;
      rdNext[15:8] = errCode_reg;
      rdNext[`F_RPT] = reportReady_reg;
      rdNext[`F_BUSY] = state_reg;
    end else if (regAddr == `A_L2) rdNext = snapL2_reg;
    else if (regAddr == `A_L3) rdNext = snapL3_reg;
    else if (regAddr == `A_L7) rdNext = snapL7_reg;
    else if (regAddr == `A_L8) rdNext = snapL8_reg;
    else if (regAddr == `A_L15) rdNext = snapL15_reg;
  end

  // ----------------------------------------
  // Settings and status
  // ----------------------------------------
  // Spans go to all three elements at once
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 14; i = i + 1) begin
        assignItem[i] <= `IT_NONE;
        assignElem[i] <= `EL_1;
      end
      for (i = 0; i < 3; i = i + 1) begin
        curSpan[i] <= `CUR_RST;
        voltSpan[i] <= `VOLT_RST;
      end
      queryCh_reg <= `CH_MIN;
      gain_reg <= `GAIN_RST;
      wiring_reg <= `WIRE_RST;
      group_reg <= `GRP_RST;
      modeB_reg <= 1'b0;
      curAuto_reg <= 1'b0;
      voltAuto_reg <= 1'b0;
      measMode_reg <= 2'd0;
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= regRead ? rdNext : 32'h0000_0000;
      if (doAssign) begin
        assignItem[wCh - `CH_MIN] <= wItem;
        assignElem[wCh - `CH_MIN] <= wElem;
      end
      if (regWrite && regAddr == `A_QCH && !errSet) queryCh_reg <= wCh;
      for (i = 0; i < 3; i = i + 1) begin
        if (doCur) curSpan[i] <= wSpan;
        if (doVolt) voltSpan[i] <= wSpan;
      end
      if (doGain) gain_reg <= wGain;
      if (doWire) wiring_reg <= wWire;
      if (regWrite && regAddr == `A_GROUP) begin
        group_reg <= regWrData[`F_GRP];
        modeB_reg <= regWrData[`F_MODEB];
      end
      if (doAuto) begin
        curAuto_reg <= regWrData[`F_CAUTO];
        voltAuto_reg <= regWrData[`F_VAUTO];
        measMode_reg <= regWrData[`F_MODE];
      end
    end
  end

  // Error flag and report snapshot; a new error beats a clear
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      errFlag <= 1'b0;
      errCode_reg <= 8'h00;
      reportReady_reg <= 1'b0;
      snapL2_reg <= 32'h0000_0000;
      snapL3_reg <= 32'h0000_0000;
      snapL7_reg <= 32'h0000_0000;
      snapL8_reg <= 32'h0000_0000;
      snapL15_reg <= 32'h0000_0000;
    end else begin
      if (errSet) begin
        errFlag <= 1'b1;
        errCode_reg <= errSetCode;
      end else if (regWrite && regAddr == `A_STAT && regWrData[`F_ERR]) begin
        errFlag <= 1'b0;
      end
      if (doSnap) begin
        reportReady_reg <= 1'b1;
        // Element 1 stands for all elements
        snapL2_reg <= {23'd0, voltAuto_reg, 3'd0, voltSpan[0]};
        snapL3_reg <= {23'd0, curAuto_reg, 3'd0, curSpan[0]};
        snapL7_reg <= {30'd0, measMode_reg};
        snapL8_reg <= {5'd0, gain_reg};
        snapL15_reg <= {30'd0, group_reg};
      end else if (regWrite && regAddr == `A_STAT && regWrData[`F_RPT]) begin
        reportReady_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Record sequencer
  // ----------------------------------------
  wire [7:0] fieldByte;
  wire       lastByte = (chIdx_reg == `LAST_CH) && (pos_reg == `P_SEP - 5'd1);

  record_field_formatter fieldGen (
    .chIdx   (chIdx_reg),
    .pos     (pos_reg),
    .item    (assignItem[chIdx_reg]),
    .elem    (assignElem[chIdx_reg]),
    .freqCur (measFreqCur[chIdx_reg]),
    .sign    (measSign[chIdx_reg]),
    .digits  (measDigits[chIdx_reg * 28 +: 28]),
    .point   (measPoint[chIdx_reg * 3 +: 3]),
    .expCode (measExp[chIdx_reg * 2 +: 2]),
    .state   (measState[chIdx_reg * 2 +: 2]),
    .byteOut (fieldByte)
  );

  // One byte per accepted handshake; stalls while the sink is busy
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      chIdx_reg <= 2'd0;
      pos_reg <= 5'd0;
      outByte <= 8'h00;
      outValid <= 1'b0;
      outLast <= 1'b0;
    end else begin
      if (outValid && outReady) begin
        outValid <= 1'b0;
        outLast <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (doRecord) begin
            state_reg <= ST_SEND;
            chIdx_reg <= 2'd0;
            pos_reg <= 5'd0;
          end
        end
        ST_SEND: begin
          if (!outValid || outReady) begin
            outValid <= 1'b1;
            outLast <= lastByte;
            outByte <= (pos_reg == `P_SEP) ? 8'h2c : fieldByte;
            if (lastByte) begin
              state_reg <= ST_IDLE;
            end else if (pos_reg == `P_SEP) begin
              pos_reg <= 5'd0;
              chIdx_reg <= chIdx_reg + 2'd1;
            end else begin
              pos_reg <= pos_reg + 5'd1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verilog/record_field_formatter.v ----
// Purpose: Byte generator for one channel field of a measurement record
// Assumes: Position 0..23 within the field, inputs stable while read
// Notes:   Purely combinational; the caller registers the byte
`timescale 1ns/1ns
`default_nettype none
`include "formatter_regs.vh"
module record_field_formatter (
  // Field selection
  input  wire [1:0]  chIdx,
  input  wire [4:0]  pos,
  input  wire [5:0]  item,
  input  wire [2:0]  elem,
  // Measured value
  input  wire        freqCur,
  input  wire        sign,
  input  wire [27:0] digits,
  input  wire [2:0]  point,
  input  wire [1:0]  expCode,
  input  wire [1:0]  state,
  // Result
  output reg  [7:0]  byteOut
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Unit text per item, three characters
  function [23:0] unitText;
    input [5:0] it;
    begin
      case (it)
        `IT_V:   unitText = 24'h562020;
        `IT_A:   unitText = 24'h412020;
        `IT_W:   unitText = 24'h572020;
        `IT_VAR: unitText = 24'h564152;
        `IT_VA:  unitText = 24'h564120;
        `IT_FRQ: unitText = 24'h485a20;
        `IT_WH:  unitText = 24'h576820;
        `IT_AH:  unitText = 24'h416820;
        `IT_DEG: unitText = 24'h444547;
        `IT_VPK: unitText = 24'h56706b;
        `IT_APK: unitText = 24'h41706b;
        `IT_WHP: unitText = 24'h57682b;
        `IT_WHN: unitText = 24'h57682d;
        `IT_AHP: unitText = 24'h41682b;
        `IT_AHN: unitText = 24'h41682d;
        default: unitText = 24'h202020;
      endcase
    end
  endfunction

  // Tens digit of a type code below 40
  function [7:0] tensChar;
    input [5:0] t;
    begin
      if (t < 6'd10) tensChar = 8'h30;
      else if (t < 6'd20) tensChar = 8'h31;
      else if (t < 6'd30) tensChar = 8'h32;
      else tensChar = 8'h33;
    end
  endfunction

  reg  [5:0]  dType;
  reg  [5:0]  tensVal;
  reg  [4:0]  j;
  reg  [2:0]  k;
  reg  [23:0] unit;
  reg  [3:0]  dig;
  wire [7:0]  chOff = {6'h00, chIdx};

  // ----------------------------------------
  // Byte select
  // ----------------------------------------
  always @* begin
    // Frequency splits by its source
    dType = (item == `IT_FRQ && freqCur) ? `IT_FCUR : item;
    tensVal = (dType < 6'd10) ? 6'd0 : (dType < 6'd20) ? 6'd10 :
              (dType < 6'd30) ? 6'd20 : 6'd30;
    unit = unitText(item);
    j = pos - `P_MANT;
    k = (j[2:0] <= point) ? j[2:0] : j[2:0] - 3'd1;
    dig = digits[27 - 4 * k -: 4];
    byteOut = 8'h20;
    case (pos)
      5'd0: byteOut = 8'h44;
      5'd1: byteOut = 8'h41 + chOff;
      5'd2: byteOut = tensChar(dType);
      5'd3: byteOut = 8'h30 + {2'b00, (dType - tensVal)};
      5'd4: byteOut = 8'h45;
      5'd5: byteOut = 8'h41 + chOff;
      5'd6: byteOut = 8'h30 + {5'd0, elem};
      `P_STATE: byteOut = (state == 2'd0) ? 8'h4e :
                          (state == 2'd2) ? 8'h4f : 8'h49;
      `P_UNIT: byteOut = unit[23:16];
      5'd9: byteOut = unit[15:8];
      5'd10: byteOut = unit[7:0];
      `P_HEND: byteOut = 8'h2c;
      `P_SIGN: byteOut = sign ? 8'h2d : 8'h20;
      `P_EXPE: byteOut = 8'h45;
      5'd22: byteOut = (expCode == 2'd0) ? 8'h2d : 8'h2b;
      5'd23: byteOut = (expCode == 2'd1) ? 8'h30 :
                       (expCode == 2'd3) ? 8'h36 : 8'h33;
      default: begin
        // Mantissa: seven digits with an optional point
        if (pos >= `P_MANT && pos < `P_EXPE) begin
          if (j[3:0] == point + 4'd1) byteOut = 8'h2e;
          else if (point < 3'd7 || j[2:0] < 3'd7) byteOut = 8'h30 + {4'h0, dig};
        end
      end
    endcase
    // Elapsed-time item on channel 2 uses a fixed tag
    if (chIdx == 2'd1 && dType == `IT_ETIME && pos < 5'd4) begin
      byteOut = (pos == 5'd0) ? 8'h44 : (pos == 5'd1) ? 8'h42 :
                (pos == 5'd2) ? 8'h34 : 8'h20;
    end
  end
endmodule
`default_nettype wire
